// [clkout_cfg_map.svh]
// Register offsets, field positions and reset values of the clock output config bank
`ifndef CLKOUT_CFG_MAP_SVH
`define CLKOUT_CFG_MAP_SVH
// Offsets are register indices; byte address = 4 * index
`define IDX_SYSTEM_EVENT_FLAGS 12'h0f7
`define IDX_INPUT_LOSS_EVENT_FLAGS 12'h0f8
`define IDX_INIT_DONE_STATUS 12'h0fe
`define IDX_GLOBAL_OUTPUT_DISABLE 12'h102
`define IDX_DRIVER0_POWER_ENABLE_CTRL 12'h112
`define IDX_DRIVER0_SIGNALLING_CFG 12'h113
`define IDX_DRIVER0_SWING_CFG 12'h114
`define IDX_DRIVER0_SOURCE_POLARITY 12'h115
`define IDX_IRQ_MASK 12'h1f0
`define IDX_DRIVER_STATUS 12'h1f1
`define IDX_PAGE_SELECT 12'h0ff
// In-page location of the ready byte, repeated on every page
`define INIT_DONE_PAGE_OFS 8'hfe
`define INIT_DONE_VALUE 8'h0f
`define INIT_NOT_DONE_VALUE 8'h00
// Field positions
`define POS_POWER_DOWN 0
`define POS_OUTPUT_ENABLE 1
`define POS_FORCE_DIV2 2
`define POS_SYNC_EN 3
`define POS_SUPPLY_SEL_EN 3
// Reset values
`define RST_GLOBAL_OUTPUT_DISABLE 8'h01
`define RST_POWER_ENABLE_CTRL 8'h01
`define RST_SIGNALLING_CFG 8'h01
`define RST_SWING_CFG 8'h00
`define RST_SOURCE_POLARITY 8'h08
`define RST_IRQ_MASK 8'h00
// Start-up time
`define INIT_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [clkout_cfg_pkg.sv]
// Types of the clock output config bank
package clkout_cfg_pkg;
   typedef enum logic [2:0]
   {
      fmt_reserved0 = 3'h0,
      fmt_diff_normal = 3'h1,
      fmt_diff_low_power = 3'h2,
      fmt_lvcmos = 3'h4
   } signalling_format_t;
   typedef enum logic [1:0]
   {
      supply_3v3 = 2'h0,
      supply_1v8 = 2'h1,
      supply_2v5 = 2'h2,
      supply_reserved = 2'h3
   } supply_select_t;
   typedef enum logic [1:0]
   {
      inv_none = 2'h0,
      inv_complement = 2'h1,
      inv_both = 2'h2,
      inv_true = 2'h3
   } polarity_invert_t;
   // Event inputs from the analogue monitors
   typedef struct packed
   {
      logic [3:0] input_loss_flags;
      logic bus_timeout_flag;
      logic oscillator_loss_flag;
      logic lock_loss_flag;
      logic reference_loss_flag;
      logic crystal_loss_flag;
      logic input_cal_flag;
   } event_in_t;
   // Decoded driver controls
   typedef struct packed
   {
      logic powered;
      logic active;
      logic weak_pull_low;
      logic static_level;
      logic force_div_by_two;
      logic [1:0] source_sel;
      logic source_valid;
      signalling_format_t signalling_format;
      logic format_valid;
      logic driver_sync_enable;
      logic [1:0] single_ended_impedance;
      logic [3:0] common_mode_level;
      logic [2:0] swing_level;
      supply_select_t supply_select;
      logic supply_select_enable;
      logic true_invert;
      logic complement_invert;
   } driver_ctrl_t;
   typedef enum logic [1:0]
   {
      st_reset = 2'b00,
      st_init = 2'b01,
      st_ready = 2'b11
   } init_state_t;
endpackage

// [clkout_cfg_regs.sv]
// AHB-Lite register bank for the clock output driver configuration
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "clkout_cfg_map.svh"
module clkout_cfg_regs
#(
   parameter int DIV_WIDTH = 24,
   parameter int INIT_COUNT = `INIT_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire clkout_cfg_pkg::event_in_t events,
   input wire logic [DIV_WIDTH-1:0] out_divider_value,
   output logic [DIV_WIDTH-1:0] out_divider,
   output clkout_cfg_pkg::driver_ctrl_t driver_ctrl,
   output logic init_done,
   output logic irq
);
   import clkout_cfg_pkg::*;

   logic [7:0] global_output_disable;
   logic [7:0] driver0_power_enable_ctrl;
   logic [7:0] driver0_signalling_cfg;
   logic [7:0] driver0_swing_cfg;
   logic [7:0] driver0_source_polarity;
   logic [7:0] system_event_flags;
   logic [7:0] input_loss_event_flags;
   logic [7:0] irq_mask;
   logic [7:0] page;
   logic [7:0] init_done_status;
   logic [7:0] driver_status;
   init_state_t state;
   init_state_t next_state;
   logic [15:0] init_cnt;
   logic dp_valid;
   logic dp_write;
   logic [11:0] dp_index;
   logic [11:0] ap_index;
   logic ap_valid;
   logic rd_sys;
   logic rd_loss;
   logic [7:0] next_rdata;
   logic global_en;
   logic drv_en;
   logic [7:0] sys_events;
   logic [7:0] loss_events;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Start-up sequence
   always_comb
   begin
      next_state = state;
      unique case (state)
         st_reset:
            next_state = st_init;
         st_init:
            if (init_cnt == 16'(INIT_COUNT - 1))
               next_state = st_ready;
         st_ready:
            next_state = st_ready;
         default:
            next_state = st_reset;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state <= st_reset;
      else
         state <= next_state;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         init_cnt <= 16'h0000;
      else if (state == st_init)
         init_cnt <= init_cnt + 16'h0001;
   end

   assign init_done = (state == st_ready);
   assign init_done_status = init_done ? `INIT_DONE_VALUE : `INIT_NOT_DONE_VALUE;

   // Address phase capture
   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_index = haddr[13:2];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_index <= 12'h000;
      end
      else if (hready)
      begin
         dp_valid <= ap_valid;
         dp_write <= hwrite;
         dp_index <= ap_index;
      end
   end

   // Register writes in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         global_output_disable <= `RST_GLOBAL_OUTPUT_DISABLE;
         driver0_power_enable_ctrl <= `RST_POWER_ENABLE_CTRL;
         driver0_signalling_cfg <= `RST_SIGNALLING_CFG;
         driver0_swing_cfg <= `RST_SWING_CFG;
         driver0_source_polarity <= `RST_SOURCE_POLARITY;
         irq_mask <= `RST_IRQ_MASK;
         page <= 8'h00;
      end
      else if (dp_valid && dp_write)
      begin
         unique case (dp_index)
            `IDX_GLOBAL_OUTPUT_DISABLE:
               global_output_disable <= {7'h00, hwdata[0]};
            `IDX_DRIVER0_POWER_ENABLE_CTRL:
               driver0_power_enable_ctrl <= {5'h00, hwdata[2:0]};
            `IDX_DRIVER0_SIGNALLING_CFG:
               driver0_signalling_cfg <= hwdata[7:0];
            `IDX_DRIVER0_SWING_CFG:
               driver0_swing_cfg <= {1'b0, hwdata[6:0]};
            `IDX_DRIVER0_SOURCE_POLARITY:
               driver0_source_polarity <= hwdata[7:0];
            `IDX_IRQ_MASK:
               irq_mask <= hwdata[7:0];
            `IDX_PAGE_SELECT:
               page <= hwdata[7:0];
            default:
               page <= page;
         endcase
      end
   end

   // Sticky event flags; a read clears only the bits it returned, so a new event is never lost
   assign sys_events = {2'b00, events.bus_timeout_flag, events.oscillator_loss_flag,
                        events.lock_loss_flag, events.reference_loss_flag,
                        events.crystal_loss_flag, events.input_cal_flag};
   assign loss_events = {4'h0, events.input_loss_flags};
   assign rd_sys = dp_valid && !dp_write && (dp_index == `IDX_SYSTEM_EVENT_FLAGS);
   assign rd_loss = dp_valid && !dp_write && (dp_index == `IDX_INPUT_LOSS_EVENT_FLAGS);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         system_event_flags <= 8'h00;
      else
         system_event_flags <= (system_event_flags & ~(rd_sys ? hrdata[7:0] : 8'h00))
                               | sys_events;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         input_loss_event_flags <= 8'h00;
      else
         input_loss_event_flags <= (input_loss_event_flags & ~(rd_loss ? hrdata[7:0] : 8'h00))
                                   | loss_events;
   end

   // Mask bits 0..5 gate system flags, 6..7 gate any input loss
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(system_event_flags[5:0] & irq_mask[5:0])
                | ((|input_loss_event_flags[3:0]) & (|irq_mask[7:6]));
   end

   // Driver control decode
   assign global_en = global_output_disable[0];
   assign drv_en = global_en && driver0_power_enable_ctrl[`POS_OUTPUT_ENABLE];

   always_comb
   begin
      driver_ctrl = '0;
      driver_ctrl.powered = !driver0_power_enable_ctrl[`POS_POWER_DOWN];
      driver_ctrl.weak_pull_low = driver0_power_enable_ctrl[`POS_POWER_DOWN];
      driver_ctrl.static_level = driver0_signalling_cfg[4] && !driver0_signalling_cfg[5];
      driver_ctrl.force_div_by_two = driver0_power_enable_ctrl[`POS_FORCE_DIV2];
      driver_ctrl.source_sel = driver0_source_polarity[1:0];
      driver_ctrl.source_valid = !driver0_source_polarity[2];
      driver_ctrl.signalling_format = signalling_format_t'(driver0_signalling_cfg[2:0]);
      driver_ctrl.format_valid = (driver0_signalling_cfg[2:0] == 3'h1)
                                 || (driver0_signalling_cfg[2:0] == 3'h2)
                                 || (driver0_signalling_cfg[2:0] == 3'h4);
      // Needs validity fields, so decoded after them
      driver_ctrl.active = drv_en && driver_ctrl.powered && driver_ctrl.format_valid
                           && driver_ctrl.source_valid;
      driver_ctrl.driver_sync_enable = driver0_signalling_cfg[`POS_SYNC_EN];
      driver_ctrl.single_ended_impedance = driver0_signalling_cfg[7:6];
      driver_ctrl.common_mode_level = driver0_swing_cfg[3:0];
      driver_ctrl.swing_level = driver0_swing_cfg[6:4];
      driver_ctrl.supply_select = supply_select_t'(driver0_source_polarity[5:4]);
      driver_ctrl.supply_select_enable = driver0_source_polarity[`POS_SUPPLY_SEL_EN];
      unique case (polarity_invert_t'(driver0_source_polarity[7:6]))
         inv_none:
         begin
            driver_ctrl.true_invert = 1'b0;
            driver_ctrl.complement_invert = 1'b0;
         end
         inv_complement:
         begin
            driver_ctrl.true_invert = 1'b0;
            driver_ctrl.complement_invert = 1'b1;
         end
         inv_both:
         begin
            driver_ctrl.true_invert = 1'b1;
            driver_ctrl.complement_invert = 1'b1;
         end
         inv_true:
         begin
            driver_ctrl.true_invert = 1'b1;
            driver_ctrl.complement_invert = 1'b0;
         end
      endcase
   end

   // Value 2 only when forced; a zero value passes through unchanged
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         out_divider <= '0;
      else if (driver0_power_enable_ctrl[`POS_FORCE_DIV2])
         out_divider <= DIV_WIDTH'(2);
      else
         out_divider <= out_divider_value;
   end

   assign driver_status = {4'h0, driver_ctrl.format_valid, driver_ctrl.source_valid,
                           driver_ctrl.powered, driver_ctrl.active};

   // Read data
   always_comb
   begin
      next_rdata = 8'h00;
      if (ap_index[7:0] == `INIT_DONE_PAGE_OFS)
         next_rdata = init_done_status;
      else
      begin
         unique case (ap_index)
            `IDX_SYSTEM_EVENT_FLAGS:
               next_rdata = system_event_flags;
            `IDX_INPUT_LOSS_EVENT_FLAGS:
               next_rdata = input_loss_event_flags;
            `IDX_GLOBAL_OUTPUT_DISABLE:
               next_rdata = global_output_disable;
            `IDX_DRIVER0_POWER_ENABLE_CTRL:
               next_rdata = driver0_power_enable_ctrl;
            `IDX_DRIVER0_SIGNALLING_CFG:
               next_rdata = driver0_signalling_cfg;
            `IDX_DRIVER0_SWING_CFG:
               next_rdata = driver0_swing_cfg;
            `IDX_DRIVER0_SOURCE_POLARITY:
               next_rdata = driver0_source_polarity;
            `IDX_IRQ_MASK:
               next_rdata = irq_mask;
            `IDX_DRIVER_STATUS:
               next_rdata = driver_status;
            `IDX_PAGE_SELECT:
               next_rdata = page;
            default:
               next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ap_valid && !hwrite)
         hrdata <= {24'h00_0000, next_rdata};
   end
endmodule

// [clkout_cfg_regs_assertions.sv]
// Assertion checker for the clock output config bank
`timescale 1ns/1ps
module clkout_cfg_checker
import clkout_cfg_pkg::*;
#(
   parameter int DIV_WIDTH = 24,
   parameter int INIT_COUNT = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [DIV_WIDTH-1:0] out_divider_value,
   input wire logic [DIV_WIDTH-1:0] out_divider,
   input wire clkout_cfg_pkg::driver_ctrl_t driver_ctrl,
   input wire logic init_done,
   input wire logic irq
);
   int up_cnt;
   // Edges since reset release, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         up_cnt <= 0;
      else if (up_cnt < 1000)
         up_cnt <= up_cnt + 1;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
   AST_RDATA_BYTE: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_FORCE_DIV: assert property ($past(hresetn) && $past(driver_ctrl.force_div_by_two)
      |-> out_divider == DIV_WIDTH'(2))
      else $error("forced divider not two");
   AST_DIV_VALUE: assert property ($past(hresetn) && !$past(driver_ctrl.force_div_by_two)
      |-> out_divider == $past(out_divider_value))
      else $error("divider does not follow value");
   AST_FORMAT_VALID: assert property (driver_ctrl.format_valid == (driver_ctrl.signalling_format
      inside {fmt_diff_normal, fmt_diff_low_power, fmt_lvcmos}))
      else $error("format validity wrong");
   AST_ACTIVE_NEEDS: assert property (driver_ctrl.active |-> driver_ctrl.powered
      && driver_ctrl.format_valid && driver_ctrl.source_valid)
      else $error("driver active without valid setup");
   AST_PULL_LOW: assert property (!driver_ctrl.powered |-> driver_ctrl.weak_pull_low)
      else $error("powered down driver not pulled low");
   AST_INIT_WAIT: assert property (up_cnt < INIT_COUNT |-> !init_done)
      else $error("init done too early");
   AST_INIT_DONE: assert property (up_cnt > INIT_COUNT + 2 |-> init_done)
      else $error("init done too late");
   AST_INIT_KEEP: assert property (init_done |=> init_done)
      else $error("init done dropped");
   cover property (driver_ctrl.force_div_by_two);
   cover property ($rose(irq));
   cover property (driver_ctrl.active);
endmodule
bind clkout_cfg_regs clkout_cfg_checker #(.DIV_WIDTH(DIV_WIDTH), .INIT_COUNT(INIT_COUNT))
   u_clkout_cfg_checker (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .out_divider_value(out_divider_value),
   .out_divider(out_divider), .driver_ctrl(driver_ctrl), .init_done(init_done), .irq(irq));

// [test_clkout_cfg_regs.sv]
// Self-checking testbench for the clock output config bank
`timescale 1ns/1ps
`include "clkout_cfg_map.svh"
module test_clkout_cfg_regs;
import clkout_cfg_pkg::*;
   typedef struct {logic [11:0] idx; logic wr; logic [7:0] wd; logic [7:0] exp;} row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, init_done, irq;
   logic [31:0] hrdata;
   logic [31:0] rd;
   event_in_t events = '0;
   logic [23:0] div_value = 24'h0;
   logic [23:0] out_divider;
   driver_ctrl_t ctl;
   int mismatches = 0;
   int checks_done = 0;
   logic [1:0] inv [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
   row_t rows [16] = '{'{12'h102, 0, 0, 8'h01}, '{12'h112, 0, 0, 8'h01},
      '{12'h113, 0, 0, 8'h01}, '{12'h114, 0, 0, 8'h00}, '{12'h115, 0, 0, 8'h08},
      '{12'h1f0, 0, 0, 8'h00}, '{12'h102, 1, 8'hff, 8'h01}, '{12'h112, 1, 8'hff, 8'h07},
      '{12'h113, 1, 8'ha4, 8'ha4}, '{12'h114, 1, 8'hff, 8'h7f}, '{12'h115, 1, 8'h5b, 8'h5b},
      '{12'h0f7, 1, 8'hff, 8'h00}, '{12'h200, 1, 8'hff, 8'h00}, '{12'h0fe, 0, 0, 8'h0f},
      '{12'h1fe, 1, 8'h00, 8'h0f}, '{12'h2fe, 0, 0, 8'h0f}};

   clkout_cfg_regs #(.INIT_COUNT(4)) u_clkout_cfg_regs (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .events(events), .out_divider_value(div_value),
      .out_divider(out_divider), .driver_ctrl(ctl), .init_done(init_done), .irq(irq));

   always #5 hclk = ~hclk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         summarize();
      end
   endtask

   task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata;
   endtask

   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(`IDX_INIT_DONE_STATUS, 1'b0, 8'h0);
      check("ready early", rd, {24'h0, `INIT_NOT_DONE_VALUE});
      repeat (8) @(posedge hclk);
      check("init_done", init_done, 1'b1);
      foreach (rows[i])
      begin
         if (rows[i].wr)
            bus(rows[i].idx, 1'b1, rows[i].wd);
         bus(rows[i].idx, 1'b0, 8'h0);
         check("readback", rd, {24'h0, rows[i].exp});
      end
      $display("test registers done");
      bus(`IDX_DRIVER0_POWER_ENABLE_CTRL, 1'b1, 8'h06);
      div_value <= 24'h123456;
      repeat (2) @(posedge hclk);
      check("forced div", out_divider, 32'h2);
      check("active", {ctl.active, ctl.powered, ctl.weak_pull_low}, 3'b110);
      bus(`IDX_DRIVER0_POWER_ENABLE_CTRL, 1'b1, 8'h02);
      repeat (2) @(posedge hclk);
      check("div value", out_divider, 32'h123456);
      div_value <= 24'h0;
      repeat (2) @(posedge hclk);
      check("zero div", out_divider, 32'h0);
      $display("test divider done");
      bus(`IDX_GLOBAL_OUTPUT_DISABLE, 1'b1, 8'h00);
      @(posedge hclk);
      check("global off", ctl.active, 1'b0);
      bus(`IDX_GLOBAL_OUTPUT_DISABLE, 1'b1, 8'h01);
      bus(`IDX_DRIVER0_POWER_ENABLE_CTRL, 1'b1, 8'h03);
      @(posedge hclk);
      check("power down", {ctl.powered, ctl.weak_pull_low, ctl.active}, 3'b010);
      bus(`IDX_DRIVER0_POWER_ENABLE_CTRL, 1'b0 + 1'b1, 8'h02);
      for (int i = 0; i < 8; i++)
      begin
         bus(`IDX_DRIVER0_SIGNALLING_CFG, 1'b1, {2'h0, i[1:0], 1'b0, i[2:0]});
         bus(`IDX_DRIVER0_SOURCE_POLARITY, 1'b1, {i[1:0], i[1:0], 1'b1, i[2:0]});
         @(posedge hclk);
         check("format", ctl.format_valid, i == 1 || i == 2 || i == 4);
         check("source", {ctl.source_valid, ctl.supply_select}, {i < 4, i[1:0]});
         check("active", ctl.active, (i == 1 || i == 2) && i < 4);
         check("invert", {ctl.true_invert, ctl.complement_invert}, inv[i[1:0]]);
         check("dis level", ctl.static_level, i[1:0] == 2'h1);
      end
      $display("test decode done");
      events.lock_loss_flag <= 1'b1;
      @(posedge hclk);
      events.lock_loss_flag <= 1'b0;
      events.input_loss_flags <= 4'h5;
      @(posedge hclk);
      events.input_loss_flags <= 4'h0;
      repeat (2) @(posedge hclk);
      check("masked irq", irq, 1'b0);
      bus(`IDX_SYSTEM_EVENT_FLAGS, 1'b0, 8'h0);
      check("sys flags", rd, 32'h08);
      bus(`IDX_INPUT_LOSS_EVENT_FLAGS, 1'b0, 8'h0);
      check("loss flags", rd, 32'h05);
      bus(`IDX_SYSTEM_EVENT_FLAGS, 1'b0, 8'h0);
      check("cleared", rd, 32'h0);
      bus(`IDX_IRQ_MASK, 1'b1, 8'h08);
      events.lock_loss_flag <= 1'b1;
      @(posedge hclk);
      events.lock_loss_flag <= 1'b0;
      repeat (3) @(posedge hclk);
      check("irq", irq, 1'b1);
      bus(`IDX_SYSTEM_EVENT_FLAGS, 1'b0, 8'h0);
      repeat (2) @(posedge hclk);
      check("irq cleared", irq, 1'b0);
      fork
         bus(`IDX_SYSTEM_EVENT_FLAGS, 1'b0, 8'h0);
         begin
            events.crystal_loss_flag <= 1'b1;
            @(posedge hclk);
            events.crystal_loss_flag <= 1'b0;
         end
      join
      check("read before event", rd, 32'h0);
      bus(`IDX_SYSTEM_EVENT_FLAGS, 1'b0, 8'h0);
      check("event kept", rd, 32'h02);
      $display("test events done");
      div_value <= 24'h0000ff;
      events.lock_loss_flag <= 1'b1;
      @(posedge hclk);
      events.lock_loss_flag <= 1'b0;
      repeat (3) @(posedge hclk);
      check("irq before reset", irq, 1'b1);
      check("div before reset", out_divider, 32'hff);
      hresetn <= 1'b0;
      @(posedge hclk);
      check("reset irq", irq, 1'b0);
      check("reset div", out_divider, 32'h0);
      check("reset init", init_done, 1'b0);
      hresetn <= 1'b1;
      bus(`IDX_INIT_DONE_STATUS, 1'b0, 8'h0);
      check("ready early again", rd, {24'h0, `INIT_NOT_DONE_VALUE});
      bus(`IDX_IRQ_MASK, 1'b0, 8'h0);
      check("mask reset", rd, {24'h0, `RST_IRQ_MASK});
      repeat (8) @(posedge hclk);
      bus(`IDX_INIT_DONE_STATUS, 1'b0, 8'h0);
      check("ready again", rd, {24'h0, `INIT_DONE_VALUE});
      $display("test reset done");
      summarize();
   end
endmodule
